// >>> verilog/card_seq_pkg.sv
package card_seq_pkg;

    // sequencer states
    typedef enum logic [2:0] {
        S_IDLE,
        S_POWER,
        S_WAIT_ATR,
        S_RECEIVE,
        S_DEACT,
        S_READY,
        S_REJECT
    } seq_state_e;

    // supply class masks, laid out as in the class indicator byte
    localparam logic [2:0] CLASS_NONE = 3'h0;
    localparam logic [2:0] CLASS_A    = 3'h1;
    localparam logic [2:0] CLASS_B    = 3'h2;
    localparam logic [2:0] CLASS_C    = 3'h4;
    localparam int         CLASS_MSB  = 2;

    // corrupted answers tolerated at one class before giving up on it
    localparam logic [1:0] RETRY_LAST = 2'h2;
    localparam logic [1:0] RETRY_ONE  = 2'h1;

    // card clock generation
    localparam int         REF_CLK_HZ       = 20000000;
    localparam int         CARD_CLK_FAST_HZ = 5000000;
    localparam int         CARD_CLK_SLOW_HZ = 1000000;
    localparam logic [3:0] HALF_FAST        = 4'(REF_CLK_HZ / (2 * CARD_CLK_FAST_HZ));
    localparam logic [3:0] HALF_SLOW        = 4'(REF_CLK_HZ / (2 * CARD_CLK_SLOW_HZ));
    localparam logic [3:0] DIV_ONE          = 4'h1;

    localparam logic [19:0] TIMER_ONE = 20'h00001;

endpackage

// >>> verilog/card_supply_class_sequencer.sv
// Function
// - Supply class selection finishes before the card is reported ready for any other activity.
// - The first activation uses the lowest supply class the terminal supports.
// - With no answer to reset, the card is powered down and brought up at the next higher class if the terminal supports it, else rejected.
// - An answer received is examined for the supply classes the card supports.
// - If the card does not support the applied class, it is reactivated at a class the card indicated; here once only, to a class both support, else rejected.
// - A corrupted answer causes at least three activations at the same class before rejection.
// - After three consecutive corrupted answers a step to the next higher class may be tried.
// - Such a step goes only to the immediately next higher class, never skipping one.
// - The terminal drives the card clock itself.
// - The card clock generator runs at one of two rates, one or five megahertz, selected by clk_slow_in.
// - The card clock high time stays between forty and sixty percent of the period.
`timescale 1ns/1ps
`default_nettype none

module card_supply_class_sequencer
    import card_seq_pkg::*;
#(
    parameter logic [19:0] RST_HOLD_CYCLES = 20'h01F40,
    parameter logic [19:0] ATR_WAIT_CYCLES = 20'hC3500,
    parameter logic [19:0] DEACT_CYCLES    = 20'h00FA0
) (
    // clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       rst_in,
    // user control
    input  wire logic       start_in,
    input  wire logic       stop_in,
    input  wire logic       clk_slow_in,
    input  wire logic       step_up_en_in,
    input  wire logic [2:0] term_classes_in,
    // answer parser results
    input  wire logic       atr_done_in,
    input  wire logic       atr_corrupt_in,
    input  wire logic [7:0] class_indicator_byte_in,
    // card contacts
    output logic            card_vcc_en_out,
    output logic [2:0]      card_class_out,
    output logic            card_rst_n_out,
    output logic            card_clk_out,
    input  wire logic       card_io_in,
    output logic            card_io_out,
    output logic            card_io_oe_n_out,
    // status
    output logic            atr_window_out,
    output logic            card_ready_out,
    output logic            reject_out,
    output logic            busy_out
);

    seq_state_e  st;
    seq_state_e  next_st;
    logic [2:0]  cur_class;
    logic [2:0]  next_class;
    logic [1:0]  retry_cnt;
    logic [1:0]  next_retry;
    logic        switched;
    logic        next_switched;
    logic [19:0] timer;
    logic [3:0]  div_cnt;
    logic        clk_slow;
    logic        io_s1;
    logic        io_s2;
    logic        io_q;
    logic [3:0]  hi_cnt;

    // class arithmetic
    wire logic [2:0] card_classes = class_indicator_byte_in[CLASS_MSB:0];
    wire logic [2:0] common       = card_classes & term_classes_in;
    wire logic [2:0] lowest_term  = term_classes_in[2] ? CLASS_C :
                                    term_classes_in[1] ? CLASS_B :
                                    term_classes_in[0] ? CLASS_A : CLASS_NONE;
    wire logic [2:0] common_low   = common[2] ? CLASS_C :
                                    common[1] ? CLASS_B :
                                    common[0] ? CLASS_A : CLASS_NONE;
    wire logic [2:0] higher       = cur_class >> 1;
    wire logic       higher_ok    = |(higher & term_classes_in);
    wire logic       cur_ok       = |(cur_class & card_classes);

    // event decode
    wire logic       io_fall      = io_q & ~io_s2;
    wire logic       hold_end     = (timer == RST_HOLD_CYCLES - TIMER_ONE);
    wire logic       atr_end      = (timer == ATR_WAIT_CYCLES - TIMER_ONE);
    wire logic       deact_end    = (timer == DEACT_CYCLES - TIMER_ONE);
    wire logic       no_answer    = (st == S_WAIT_ATR) & ~io_fall & atr_end;
    wire logic       corrupt_evt  = (st == S_RECEIVE) &
                                    ((atr_done_in & atr_corrupt_in) | (~atr_done_in & atr_end));
    wire logic       good_evt     = (st == S_RECEIVE) & atr_done_in & ~atr_corrupt_in;
    wire logic       start_ok     = start_in & (lowest_term != CLASS_NONE);
    wire logic       powered_nx   = (next_st == S_POWER) | (next_st == S_WAIT_ATR) |
                                    (next_st == S_RECEIVE) | (next_st == S_READY);
    wire logic       rst_rel_nx   = (next_st == S_WAIT_ATR) | (next_st == S_RECEIVE) |
                                    (next_st == S_READY);
    wire logic [3:0] half_cnt     = clk_slow ? HALF_SLOW : HALF_FAST;
    wire logic       div_wrap     = (div_cnt == half_cnt - DIV_ONE);

    always_comb begin
        next_st       = st;
        next_class    = cur_class;
        next_retry    = retry_cnt;
        next_switched = switched;
        case (st)
            S_IDLE, S_REJECT: begin
                if (start_ok) begin
                    next_st       = S_POWER;
                    next_class    = lowest_term;
                    next_retry    = 2'h0;
                    next_switched = 1'b0;
                end else if (start_in) begin
                    next_st = S_REJECT;
                end
            end
            S_POWER: begin
                if (hold_end) begin
                    next_st = S_WAIT_ATR;
                end
            end
            S_WAIT_ATR: begin
                // first start bit opens the answer
                if (io_fall) begin
                    next_st = S_RECEIVE;
                end else if (no_answer) begin
                    if (higher_ok) begin
                        next_st    = S_DEACT;
                        next_class = higher;
                        next_retry = 2'h0;
                    end else begin
                        next_st = S_REJECT;
                    end
                end
            end
            S_RECEIVE: begin
                if (corrupt_evt) begin
                    if (retry_cnt < RETRY_LAST) begin
                        next_st    = S_DEACT;
                        next_retry = retry_cnt + RETRY_ONE;
                    end else if (step_up_en_in && higher_ok) begin
                        next_st    = S_DEACT;
                        next_class = higher;
                        next_retry = 2'h0;
                    end else begin
                        next_st = S_REJECT;
                    end
                end else if (good_evt) begin
                    if (cur_ok) begin
                        next_st = S_READY;
                    end else if (!switched && common_low != CLASS_NONE) begin
                        next_st       = S_DEACT;
                        next_class    = common_low;
                        next_retry    = 2'h0;
                        next_switched = 1'b1;
                    end else begin
                        next_st = S_REJECT;
                    end
                end
            end
            S_DEACT: begin
                if (deact_end) begin
                    next_st = S_POWER;
                end
            end
            S_READY: begin
                if (stop_in) begin
                    next_st = S_IDLE;
                end
            end
            default: begin
                next_st = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            st        <= S_IDLE;
            cur_class <= CLASS_NONE;
            retry_cnt <= 2'h0;
            switched  <= 1'b0;
            timer     <= 20'h00000;
        end else begin
            st        <= next_st;
            cur_class <= next_class;
            retry_cnt <= next_retry;
            switched  <= next_switched;
            timer     <= (next_st != st) ? 20'h00000 : timer + TIMER_ONE;
        end
    end

    // contact levels follow the next state so they change with the class
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            card_vcc_en_out <= 1'b0;
            card_rst_n_out  <= 1'b0;
            atr_window_out  <= 1'b0;
            card_ready_out  <= 1'b0;
            reject_out      <= 1'b0;
            busy_out        <= 1'b0;
        end else begin
            card_vcc_en_out <= powered_nx;
            card_rst_n_out  <= rst_rel_nx;
            atr_window_out  <= (next_st == S_WAIT_ATR) | (next_st == S_RECEIVE);
            card_ready_out  <= (next_st == S_READY);
            reject_out      <= (next_st == S_REJECT);
            busy_out        <= powered_nx | (next_st == S_DEACT);
        end
    end

    assign card_class_out   = cur_class;
    // the line is only listened to; the pull-up holds it high
    assign card_io_out      = 1'b0;
    assign card_io_oe_n_out = 1'b1;

    // io comes from the card, asynchronous to ref_clk_in
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            io_s1 <= 1'b1;
            io_s2 <= 1'b1;
            io_q  <= 1'b1;
        end else begin
            io_s1 <= card_io_in;
            io_s2 <= io_s1;
            io_q  <= io_s2;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            clk_slow <= 1'b0;
        end else if (st == S_IDLE || st == S_REJECT) begin
            clk_slow <= clk_slow_in;
        end
    end

    // even divider gives a 50 percent high time
    always_ff @(posedge ref_clk_in) begin
        // stop on the supply edge itself, so no clock level outlives vcc
        if (rst_in || !powered_nx) begin
            div_cnt      <= 4'h0;
            card_clk_out <= 1'b0;
        end else if (div_wrap) begin
            div_cnt      <= 4'h0;
            card_clk_out <= ~card_clk_out;
        end else begin
            div_cnt      <= div_cnt + DIV_ONE;
        end
    end

    // high-time counter read only by the duty check
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || !card_clk_out) begin
            hi_cnt <= 4'h0;
        end else begin
            hi_cnt <= hi_cnt + DIV_ONE;
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_rst_held;
        !card_rst_n_out [*8];
    endsequence

    sequence s_powered_up;
        $rose(card_vcc_en_out);
    endsequence

    AST_FIRST_LOWEST: assert property (
        ((st == S_IDLE) && start_ok) |=> (cur_class == $past(lowest_term)) && card_vcc_en_out)
        else $error("first activation not at lowest terminal class");

    AST_NO_ANSWER_STEP: assert property (
        (no_answer && higher_ok) |=> (st == S_DEACT) && !card_vcc_en_out && (cur_class == $past(higher)))
        else $error("silent card not stepped to next higher class");

    AST_CLASS_HELD: assert property (
        (card_vcc_en_out && $past(card_vcc_en_out)) |-> $stable(cur_class))
        else $error("supply class changed while card powered");

    AST_CARD_CLASS: assert property (
        (good_evt && !cur_ok && !switched && common_low != CLASS_NONE)
        |=> (cur_class == $past(common_low)) && (st == S_DEACT))
        else $error("unsupported class not replaced by a card class");

    AST_RETRY_SAME: assert property (
        (corrupt_evt && retry_cnt < RETRY_LAST) |=> $stable(cur_class) && (st == S_DEACT))
        else $error("corrupted answer not retried at same class");

    AST_STEP_NEXT_ONLY: assert property (
        (corrupt_evt && retry_cnt == RETRY_LAST && step_up_en_in && higher_ok)
        |=> (cur_class == $past(higher)))
        else $error("retry step skipped a class");

    AST_REJECT_OFF: assert property (
        reject_out |-> !card_vcc_en_out && !card_clk_out && !card_rst_n_out)
        else $error("card left powered after rejection");

    AST_CLK_DUTY: assert property (
        ($fell(card_clk_out) && card_vcc_en_out) |-> (hi_cnt == half_cnt))
        else $error("card clock high time off half period");

    AST_CLK_POWERED: assert property (
        card_clk_out |-> card_vcc_en_out)
        else $error("card clock running without supply");

    AST_RST_AFTER_POWER: assert property (
        s_powered_up |-> s_rst_held)
        else $error("reset released too soon after power up");

endmodule

`default_nettype wire

// >>> tb/card_model.sv
`timescale 1ns/1ps
`default_nettype none

module card_model
    import card_seq_pkg::*;
(
    // terminal side
    input  wire logic       ref_clk_in,
    input  wire logic       card_vcc_en_in,
    input  wire logic       card_rst_n_in,
    input  wire logic       card_clk_in,
    // behaviour: 0 silent, 1 good answer, 2 corrupted answer
    input  wire logic [1:0] mode_in,
    input  wire logic [2:0] classes_in,
    // answer to the terminal
    output logic            card_io_out,
    output logic            atr_done_out,
    output logic            atr_corrupt_out,
    output logic [7:0]      class_byte_out
);
    logic io_drv;

    // pull-up holds the line high while the card is unpowered
    assign card_io_out = card_vcc_en_in ? io_drv : 1'h1;

    initial begin
        io_drv = 1'h1;
        atr_done_out = 1'h0;
        atr_corrupt_out = 1'h0;
        class_byte_out = 8'h00;
        forever begin
            @(posedge card_rst_n_in);
            if (mode_in != 2'h0) begin
                repeat (4) @(posedge card_clk_in);
                @(posedge ref_clk_in);
                io_drv <= 1'h0;
                repeat (20) @(posedge ref_clk_in);
                io_drv <= 1'h1;
                atr_done_out <= 1'h1;
                atr_corrupt_out <= (mode_in == 2'h2);
                class_byte_out <= {5'h00, classes_in};
                @(posedge ref_clk_in);
                atr_done_out <= 1'h0;
                atr_corrupt_out <= 1'h0;
                // byte is meaningless once the strobe drops
                class_byte_out <= ~class_byte_out;
            end
        end
    end
endmodule

`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb
    import card_seq_pkg::*;
;
    logic        ref_clk_in;
    logic        rst_in;
    logic        start_in;
    logic        stop_in;
    logic        clk_slow_in;
    logic        step_up_en_in;
    logic [2:0]  term_classes_in;
    logic [1:0]  mode;
    logic [2:0]  classes;
    logic        atr_done;
    logic        atr_corrupt;
    logic [7:0]  class_byte;
    logic        card_io;
    logic        vcc;
    logic [2:0]  card_class;
    logic        rst_n;
    logic        card_clk;
    logic        card_ready;
    logic        reject;
    logic        atr_window;
    logic        busy;
    logic        io_oe_n;
    logic        io_o;
    int          win;
    logic [26:0] hist;
    int          n;
    int          err_count;
    int          comparisons;

    card_supply_class_sequencer #(
        .RST_HOLD_CYCLES(20'h00014),
        .ATR_WAIT_CYCLES(20'h000C8),
        .DEACT_CYCLES   (20'h0000A)
    ) uut (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .start_in(start_in), .stop_in(stop_in),
        .clk_slow_in(clk_slow_in), .step_up_en_in(step_up_en_in), .term_classes_in(term_classes_in),
        .atr_done_in(atr_done), .atr_corrupt_in(atr_corrupt), .class_indicator_byte_in(class_byte),
        .card_vcc_en_out(vcc), .card_class_out(card_class), .card_rst_n_out(rst_n),
        .card_clk_out(card_clk), .card_io_in(card_io), .card_io_out(io_o), .card_io_oe_n_out(io_oe_n),
        .atr_window_out(atr_window), .card_ready_out(card_ready), .reject_out(reject), .busy_out(busy)
    );

    card_model card (
        .ref_clk_in(ref_clk_in), .card_vcc_en_in(vcc), .card_rst_n_in(rst_n), .card_clk_in(card_clk),
        .mode_in(mode), .classes_in(classes), .card_io_out(card_io), .atr_done_out(atr_done),
        .atr_corrupt_out(atr_corrupt), .class_byte_out(class_byte)
    );

    initial begin
        ref_clk_in = 1'h0;
        forever #25 ref_clk_in = ~ref_clk_in;
    end

    task give_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %0h expected %0h", $time, msg, got, exp);
        end
    endtask

    task tick();
        @(posedge ref_clk_in);
        #1;
    endtask

    // runs one activation sequence, logging the class applied at each power-up
    task activate(input logic [2:0] term, input logic [2:0] cls, input logic [1:0] md,
                  input logic step, input logic slow);
        int  i;
        logic was_on;
        @(posedge ref_clk_in);
        term_classes_in <= term;
        classes <= cls;
        mode <= md;
        step_up_en_in <= step;
        clk_slow_in <= slow;
        start_in <= 1'h1;
        @(posedge ref_clk_in);
        start_in <= 1'h0;
        #1;
        hist = '0;
        n = 0;
        win = 0;
        was_on = 1'h0;
        for (i = 0; i < 20000 && card_ready !== 1'h1 && reject !== 1'h1; i++) begin
            if (vcc === 1'h1 && !was_on) begin
                hist = {hist[23:0], card_class};
                n++;
            end
            if (atr_window === 1'h1) begin
                win++;
            end
            was_on = (vcc === 1'h1);
            tick();
        end
        if (i == 20000) begin
            err_count++;
            $display("wrong value at %0t: sequence never settled", $time);
            give_verdict();
        end
    endtask

    task clk_check(input logic [3:0] half);
        int i;
        int hi;
        int lo;
        for (i = 0; i < 40 && card_clk !== 1'h0; i++) tick();
        for (i = 0; i < 40 && card_clk !== 1'h1; i++) tick();
        if (i == 40) begin
            err_count++;
            $display("wrong value at %0t: card clock never rose", $time);
            give_verdict();
        end
        for (hi = 0; hi < 40 && card_clk === 1'h1; hi++) tick();
        for (lo = 0; lo < 40 && card_clk === 1'h0; lo++) tick();
        check(hi, half, "card clock high time");
        check(lo, half, "card clock low time");
    endtask

    task power_off();
        @(posedge ref_clk_in);
        stop_in <= 1'h1;
        @(posedge ref_clk_in);
        stop_in <= 1'h0;
        tick();
        check(vcc, 1'h0, "supply after stop");
    endtask

    task t_lowest();
        activate(3'h7, CLASS_C, 2'h1, 1'h0, 1'h0);
        check(hist, CLASS_C, "first class");
        check(card_ready, 1'h1, "ready");
        check({card_ready, atr_window, busy, io_oe_n, io_o}, 5'h16, "status at ready");
        clk_check(HALF_FAST);
        power_off();
        $display("test lowest class finished");
    endtask

    task t_switch();
        activate(3'h7, 3'h3, 2'h1, 1'h0, 1'h1);
        check(hist, {CLASS_C, CLASS_B}, "class history");
        check({card_ready, card_class}, {1'h1, CLASS_B}, "ready at card class");
        clk_check(HALF_SLOW);
        power_off();
        $display("test class switch finished");
    endtask

    task t_silent();
        activate(3'h7, 3'h7, 2'h0, 1'h0, 1'h0);
        check(hist, {CLASS_C, CLASS_B, CLASS_A}, "silent history");
        check({reject, vcc}, 2'h2, "reject powered down");
        check({busy, atr_window}, 2'h0, "idle after reject");
        // three full answer windows of the shortened wait
        check(win, 32'h258, "answer window cycles");
        activate(3'h6, 3'h7, 2'h0, 1'h0, 1'h0);
        check(hist, {CLASS_C, CLASS_B}, "silent, terminal lacks top class");
        check(reject, 1'h1, "reject");
        $display("test silent card finished");
    endtask

    task t_corrupt();
        activate(3'h7, CLASS_C, 2'h2, 1'h0, 1'h0);
        check(n, 3, "corrupt attempts");
        check(hist, {CLASS_C, CLASS_C, CLASS_C}, "corrupt history");
        check({reject, vcc}, 2'h2, "reject after corrupt");
        activate(3'h7, 3'h7, 2'h2, 1'h1, 1'h0);
        check(n, 9, "stepped attempts");
        check(hist, {CLASS_C, CLASS_C, CLASS_C, CLASS_B, CLASS_B, CLASS_B, CLASS_A, CLASS_A, CLASS_A},
              "stepped history");
        $display("test corrupt answers finished");
    endtask

    task t_refuse();
        // start from idle so that the refusal has to raise the flag itself
        activate(3'h7, CLASS_C, 2'h1, 1'h0, 1'h0);
        power_off();
        check(reject, 1'h0, "no reject before refusal");
        activate(3'h0, 3'h7, 2'h1, 1'h0, 1'h0);
        check({n[3:0], reject}, 5'h01, "no class at all");
        $display("test no terminal class finished");
    endtask

    initial begin
        rst_in = 1'h1;
        start_in = 1'h0;
        stop_in = 1'h0;
        clk_slow_in = 1'h0;
        step_up_en_in = 1'h0;
        term_classes_in = 3'h7;
        mode = 2'h1;
        classes = 3'h4;
        err_count = 0;
        comparisons = 0;
        repeat (4) @(posedge ref_clk_in);
        rst_in <= 1'h0;
        tick();
        check({vcc, rst_n, card_class}, 5'h00, "outputs after reset");
        t_lowest();
        t_switch();
        t_silent();
        t_corrupt();
        t_refuse();
        give_verdict();
    end
endmodule

`default_nettype wire
